// ### hdl/dmaarc_core.sv
// Purpose: Four-channel DMA start, abort and resume control
// Assumes: AHB-Lite slave, zero wait, word access; one transfer port
// Notes: Transfer port is a req/ack pair, req held until ack or abort
// Notes on behaviour
// - NMI aborts any transfer in progress
// - Abort copies enable bits to interrupted status
// - Enable bit is bit 0 of control
// - Restart write of 1 resumes aborted channel
// - Start by software, peripheral interrupt or pin
// - Single, single-step and block transfer modes
// - Four independent channels, numbered 0 to 3
// - One-clock stop pulse aborts and saves enables
// - Count register holds transfers minus one
// - Address control 0000H is a valid setting
// - Control write 03H enables and starts channel
// - Addresses and count advance per transfer
// - Equal source and destination work normally
`timescale 1ns/100ps
module dmaarc_core (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [dmaarc_pkg::NCH-1:0] periph_irq,
  input wire logic [dmaarc_pkg::NCH-1:0] transfer_request_pin,
  input wire logic transfer_stop_input,
  input wire logic nmi,
  output logic xfer_req,
  output logic [1:0] xfer_ch,
  output logic [31:0] xfer_src,
  output logic [31:0] xfer_dst,
  input wire logic xfer_ack,
  output logic irq
);
  import dmaarc_pkg::*;

  // Engine states
  typedef enum logic {ST_IDLE, ST_XFER} dmaarc_state_t;

  // Next address for one direction code
  function automatic logic [31:0] dmaarc_next(input logic [31:0] a,
                                              input logic [1:0] dir);
    // Code zero increments, so 0000H is a usable setting
    dmaarc_next = (dir == DIR_INC) ? a + ADDR_STEP :
                  (dir == DIR_DEC) ? a - ADDR_STEP : a;
  endfunction : dmaarc_next

  // Lowest pending channel wins
  function automatic logic [1:0] dmaarc_first(input logic [3:0] v);
    dmaarc_first = v[0] ? 2'd0 : v[1] ? 2'd1 : v[2] ? 2'd2 : 2'd3;
  endfunction : dmaarc_first

  // Bus slave state
  logic act_q;
  logic wr_q;
  logic [7:0] a_q;
  logic [31:0] hrdata_q;
  // Channel registers
  logic [31:0] src_q [NCH];
  logic [31:0] dst_q [NCH];
  logic [15:0] cnt_q [NCH];
  logic [15:0] adc_q [NCH];
  logic [7:0] ctl_q [NCH];
  // Per-channel flags
  logic [NCH-1:0] pend_q;
  logic [NCH-1:0] istat_q;
  // Engine
  dmaarc_state_t state_q;
  logic [1:0] cur_q;
  logic [31:0] xsrc_q;
  logic [31:0] xdst_q;
  // Synchronised pins and their previous values
  logic [5:0] sy;
  logic [5:0] sy_q;
  logic [NCH-1:0] pirq_q;
  // Interrupt block outputs
  logic [NIRQ-1:0] irq_st;
  logic [NIRQ-1:0] irq_en;

  // Pins reach logic only after two flops
  dmaarc_sync #(.W(6)) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .d({nmi, transfer_stop_input, transfer_request_pin}),
    .q(sy)
  );

  // Edge history of pins and of peripheral interrupts
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sy_q <= '0;
      pirq_q <= '0;
    end else begin
      sy_q <= sy;
      pirq_q <= periph_irq;
    end
  end

  // Rising edges; a one-clock stop pulse is enough
  wire logic [5:0] sy_rise = sy & ~sy_q;
  wire logic [NCH-1:0] pin_rise = sy_rise[3:0];
  wire logic [NCH-1:0] pirq_rise = periph_irq & ~pirq_q;
  wire logic abort = sy_rise[5] | sy_rise[4];

  // Address phase capture
  wire logic addr_ph = hsel & htrans[1] & hready;
  wire logic wr_go = act_q & wr_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      act_q <= 1'b0;
      wr_q <= 1'b0;
      a_q <= 8'h00;
    end else begin
      act_q <= addr_ph;
      if (addr_ph) wr_q <= hwrite;
      if (addr_ph) a_q <= haddr[7:0];
    end
  end

  // Write decode of global registers and of the channel window
  wire logic we_rst = wr_go & (a_q == OFS_RST);
  wire logic we_iclr = wr_go & (a_q == OFS_IRQ_CLR);
  wire logic we_ien = wr_go & (a_q == OFS_IRQ_EN);
  wire logic ch_win = wr_go & ~a_q[7];

  // Read selection, prepared in the address phase
  wire logic [1:0] rch = haddr[6:5];
  wire logic [4:0] rfld = haddr[4:0];
  wire logic [31:0] rd_chan =
    (rfld == FLD_SRC) ? src_q[rch] :
    (rfld == FLD_DST) ? dst_q[rch] :
    (rfld == FLD_CNT) ? 32'(cnt_q[rch]) :
    (rfld == FLD_ADC) ? 32'(adc_q[rch]) :
    (rfld == FLD_CTL) ? 32'(ctl_q[rch]) : RST_WORD;
  wire logic [31:0] rd_val =
    ~haddr[7] ? rd_chan :
    (haddr[7:0] == OFS_ISTAT) ? 32'(istat_q) :
    (haddr[7:0] == OFS_IRQ_ST) ? 32'(irq_st) :
    (haddr[7:0] == OFS_IRQ_EN) ? 32'(irq_en) : RST_WORD;

  // Read data register; unmapped reads return zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) hrdata_q <= RST_WORD;
    else if (addr_ph & ~hwrite) hrdata_q <= rd_val;
  end

  // Never waits, never errors
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  // Engine decode shared by all channels
  wire logic in_xfer = (state_q == ST_XFER);
  wire logic ack_ok = in_xfer & xfer_ack & ~abort;
  wire logic [NCH-1:0] en_vec;
  wire logic [NCH-1:0] done_n;
  wire logic [NCH-1:0] last_n;
  wire logic [NCH-1:0] trig_n;
  wire logic [NCH-1:0] keep_n;
  wire logic [NCH-1:0] we_ctl_n;
  wire logic [NCH-1:0] rst_go;

  // Restart only wakes channels that were really interrupted
  assign rst_go = {NCH{we_rst}} & hwdata[NCH-1:0] & istat_q;

  // One slice per channel, all identical
  for (genvar n = 0; n < NCH; n++) begin : g_ch
    wire logic sel = ch_win & (a_q[6:5] == 2'(n));
    wire logic we_src = sel & (a_q[4:0] == FLD_SRC);
    wire logic we_dst = sel & (a_q[4:0] == FLD_DST);
    wire logic we_cnt = sel & (a_q[4:0] == FLD_CNT);
    wire logic we_adc = sel & (a_q[4:0] == FLD_ADC);
    wire logic [1:0] mode = ctl_q[n][CTL_MODE+:2];
    assign we_ctl_n[n] = sel & (a_q[4:0] == FLD_CTL);
    assign en_vec[n] = ctl_q[n][CTL_EN];
    assign done_n[n] = ack_ok & (cur_q == 2'(n));
    assign last_n[n] = (cnt_q[n] == RST_HALF);
    // Stepped and block channels stay pending until the count ends
    assign keep_n[n] = (mode == MODE_STEP) | (mode == MODE_BLOCK);
    // Three ways to start; a write of 03H is the software one
    assign trig_n[n] =
      (we_ctl_n[n] & hwdata[CTL_EN] & hwdata[CTL_SWT]) |
      (en_vec[n] & ctl_q[n][CTL_PIRQ] & pirq_rise[n]) |
      (en_vec[n] & ctl_q[n][CTL_PIN] & pin_rise[n]);

    // Source address: software load, engine advance wins
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) src_q[n] <= RST_WORD;
      else if (done_n[n]) src_q[n] <= dmaarc_next(src_q[n], adc_q[n][1:0]);
      else if (we_src) src_q[n] <= hwdata;
    end

    // Destination address, may equal the source
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) dst_q[n] <= RST_WORD;
      else if (done_n[n]) dst_q[n] <= dmaarc_next(dst_q[n], adc_q[n][3:2]);
      else if (we_dst) dst_q[n] <= hwdata;
    end

    // Remaining count minus one; kept across an abort
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) cnt_q[n] <= RST_HALF;
      else if (done_n[n] & ~last_n[n]) cnt_q[n] <= cnt_q[n] - 16'h0001;
      else if (we_cnt) cnt_q[n] <= hwdata[15:0];
    end

    // Address control
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) adc_q[n] <= RST_HALF;
      else if (we_adc) adc_q[n] <= hwdata[15:0];
    end

    // Control; trigger bit never stored, abort drops the enable
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) ctl_q[n] <= RST_CTL;
      else if (abort) ctl_q[n][CTL_EN] <= 1'b0;
      else if (we_ctl_n[n]) ctl_q[n] <= hwdata[7:0] & ~8'(1 << CTL_SWT);
      else if (done_n[n] & last_n[n]) ctl_q[n][CTL_EN] <= 1'b0;
      else if (rst_go[n]) ctl_q[n][CTL_EN] <= 1'b1;
    end

    // Pending request; a trigger in the cycle of a non-final acknowledge is kept
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) pend_q[n] <= 1'b0;
      else if (abort) pend_q[n] <= 1'b0;
      else if (done_n[n] & last_n[n]) pend_q[n] <= 1'b0;
      else if (trig_n[n] | rst_go[n]) pend_q[n] <= 1'b1;
      else if (done_n[n] & ~keep_n[n]) pend_q[n] <= 1'b0;
      else if (we_ctl_n[n] & ~hwdata[CTL_EN]) pend_q[n] <= 1'b0;
    end
  end

  // Interrupted status: abort snapshots enables, restart clears
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) istat_q <= '0;
    else if (abort) istat_q <= en_vec;
    else istat_q <= istat_q & ~rst_go;
  end

  // Requests that the engine may serve
  wire logic [NCH-1:0] ready_n = pend_q & en_vec;
  wire logic [1:0] grant = dmaarc_first(ready_n);
  wire logic cur_block = (ctl_q[cur_q][CTL_MODE+:2] == MODE_BLOCK);
  // Block mode keeps the port for its whole count
  wire logic stay = done_n[cur_q] & cur_block & ~last_n[cur_q];

  // Engine state; abort drops the request at once
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) state_q <= ST_IDLE;
    else begin
      case (state_q)
        ST_IDLE: if (|ready_n & ~abort) state_q <= ST_XFER;
        ST_XFER: if (abort | (ack_ok & ~stay)) state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Transfer port data from flops, loaded on grant or block step
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cur_q <= 2'd0;
      xsrc_q <= RST_WORD;
      xdst_q <= RST_WORD;
    end else if ((state_q == ST_IDLE) & |ready_n) begin
      cur_q <= grant;
      xsrc_q <= src_q[grant];
      xdst_q <= dst_q[grant];
    end else if (stay) begin
      xsrc_q <= dmaarc_next(src_q[cur_q], adc_q[cur_q][1:0]);
      xdst_q <= dmaarc_next(dst_q[cur_q], adc_q[cur_q][3:2]);
    end
  end

  assign xfer_req = in_xfer;
  assign xfer_ch = cur_q;
  assign xfer_src = xsrc_q;
  assign xfer_dst = xdst_q;

  // Completion and abort events to the interrupt block
  wire logic [NIRQ-1:0] ev = {({NCH{abort}} & en_vec),
                              (done_n & last_n)};

  dmaarc_irq u_irq (
    .clk(clk),
    .arst_n(arst_n),
    .set(ev),
    .clr_we(we_iclr),
    .en_we(we_ien),
    .wval(hwdata[NIRQ-1:0]),
    .status_q(irq_st),
    .enable_q(irq_en),
    .irq(irq)
  );

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  chk_abort_drops: assert property (abort |=> !xfer_req && en_vec == '0)
    else $error("abort did not stop channels");
  chk_abort_saves: assert property (abort |=> istat_q == $past(en_vec))
    else $error("enables not saved on abort");
  chk_en_bit: assert property (we_ctl_n[0] && !abort |=>
    en_vec[0] == $past(hwdata[0]))
    else $error("enable is not control bit 0");
  chk_restart_wake: assert property (rst_go[0] && !abort |=>
    en_vec[0] && pend_q[0] && !istat_q[0])
    else $error("restart did not resume channel");
  chk_pin_start: assert property (en_vec[0] && ctl_q[0][CTL_PIN] &&
    pin_rise[0] && !abort && !done_n[0] |=> pend_q[0])
    else $error("pin edge lost");
  chk_single_one: assert property (done_n[0] &&
    ctl_q[0][CTL_MODE+:2] == MODE_SINGLE && !trig_n[0] |=> !pend_q[0])
    else $error("single mode kept pending");
  chk_stop_pulse: assert property ($rose(transfer_stop_input) &&
    !sy[4] && !sy_q[4] |-> ##[1:2] abort)
    else $error("stop pulse not seen");
  chk_count_dec: assert property (done_n[1] && !last_n[1] |=>
    cnt_q[1] == $past(cnt_q[1]) - 16'h0001)
    else $error("count did not step");
  chk_addr_step: assert property (done_n[0] && adc_q[0][1:0] == DIR_INC
    |=> src_q[0] == $past(src_q[0]) + ADDR_STEP)
    else $error("source did not advance");
  chk_last_end: assert property (done_n[3] && last_n[3] |=>
    !pend_q[3] && irq_st[IRQ_TC+3])
    else $error("completion not raised");
  chk_req_hold: assert property (xfer_req && !xfer_ack && !abort |=>
    xfer_req && $stable(xfer_src))
    else $error("request dropped early");

  cov_abort_live: cover property (in_xfer && abort);
  cov_resume_end: cover property (rst_go[0] ##[1:200] (done_n[0] && last_n[0]));
  cov_block_run: cover property (stay ##1 stay);
  cov_irq: cover property (irq);
endmodule : dmaarc_core

// ### include/dmaarc_pkg.sv
// Purpose: Shared constants of the DMA abort and resume controller
// Assumes: AHB-Lite word access, byte addresses on haddr[7:0]
// Notes: Channel n occupies 32 bytes at n*32; global registers from 8'h80
package dmaarc_pkg;
  // Channel count
  localparam int NCH = 4;
  // Field offsets inside one channel window, haddr[4:0]
  localparam logic [4:0] FLD_SRC = 5'h00;
  localparam logic [4:0] FLD_DST = 5'h04;
  localparam logic [4:0] FLD_CNT = 5'h08;
  localparam logic [4:0] FLD_ADC = 5'h0c;
  localparam logic [4:0] FLD_CTL = 5'h10;
  // Global register offsets
  localparam logic [7:0] OFS_ISTAT = 8'h80;
  localparam logic [7:0] OFS_RST = 8'h84;
  localparam logic [7:0] OFS_IRQ_ST = 8'h88;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h8c;
  localparam logic [7:0] OFS_IRQ_EN = 8'h90;
  // Channel control bit positions
  localparam int CTL_EN = 0;
  localparam int CTL_SWT = 1;
  localparam int CTL_MODE = 2;
  localparam int CTL_PIRQ = 4;
  localparam int CTL_PIN = 5;
  // Transfer modes in control bits [3:2]
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_STEP = 2'h1;
  localparam logic [1:0] MODE_BLOCK = 2'h2;
  // Address direction codes, source in [1:0], destination in [3:2]
  localparam logic [1:0] DIR_INC = 2'h0;
  localparam logic [1:0] DIR_DEC = 2'h1;
  localparam logic [1:0] DIR_FIX = 2'h2;
  localparam logic [31:0] ADDR_STEP = 32'h0000_0004;
  // Interrupt status layout
  localparam int NIRQ = 8;
  localparam int IRQ_TC = 0;
  localparam int IRQ_AB = 4;
  // Reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [15:0] RST_HALF = 16'h0000;
  localparam logic [7:0] RST_CTL = 8'h00;
endpackage : dmaarc_pkg

// ### hdl/dmaarc_sync.sv
// Purpose: Two flip-flop synchroniser for a vector of pin levels
// Assumes: Each bit is an independent level, no bus coherency needed
// Notes: Only the second stage may be read by logic
`timescale 1ns/100ps
module dmaarc_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // First stage, read only by the second stage
  logic [W-1:0] meta_q;

  // Both stages clear on reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : dmaarc_sync

// ### hdl/dmaarc_irq.sv
// Purpose: Sticky event status, write-one clear and enable mask
// Assumes: Set pulses come from the same clock domain
// Notes: A set in the clear cycle keeps the bit set
`timescale 1ns/100ps
module dmaarc_irq
  import dmaarc_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [dmaarc_pkg::NIRQ-1:0] set,
  input wire logic clr_we,
  input wire logic en_we,
  input wire logic [dmaarc_pkg::NIRQ-1:0] wval,
  output logic [dmaarc_pkg::NIRQ-1:0] status_q,
  output logic [dmaarc_pkg::NIRQ-1:0] enable_q,
  output logic irq
);
  // Bits software asks to clear this cycle
  wire logic [NIRQ-1:0] clr_mask = clr_we ? wval : '0;

  // Sticky status; set wins so no event is lost
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) status_q <= '0;
    else status_q <= (status_q & ~clr_mask) | set;
  end

  // Enable mask
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) enable_q <= '0;
    else if (en_we) enable_q <= wval;
  end

  // Level output while any enabled bit stands
  assign irq = |(status_q & enable_q);
endmodule : dmaarc_irq

// ### sim/dmaarc_sys_model.sv
// Purpose: Far-side system bus model that answers transfer requests
// Assumes: One word moves per request/acknowledge handshake
// Notes: Latency comes from lat; acknowledges are counted per channel
`timescale 1ns/100ps
module dmaarc_sys_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic xfer_req,
  input wire logic [1:0] xfer_ch,
  input wire logic [7:0] lat,
  output logic xfer_ack
);
  logic [7:0] wait_q; // Cycles spent on the current request
  int acks [4] = '{0, 0, 0, 0}; // Completed words per channel
  // Answer lat + 1 cycles after the request; a withdrawn request restarts the wait
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_q <= 8'h00;
      xfer_ack <= 1'b0;
    end else if (!xfer_req || xfer_ack) begin
      wait_q <= 8'h00;
      xfer_ack <= 1'b0;
    end else if (wait_q == lat) begin
      xfer_ack <= 1'b1;
    end else begin
      wait_q <= wait_q + 8'h01;
    end
  end
  // A word counts only when both sides agree at one edge
  always @(posedge clk) begin
    if (xfer_ack && xfer_req) begin
      acks[xfer_ch] <= acks[xfer_ch] + 1;
    end
  end
endmodule : dmaarc_sys_model

// ### sim/dma_abort_resume_control_tb.sv
// Purpose: Self-checking bench for start, abort and resume control
// Assumes: Zero-wait AHB-Lite slave, far side is the bus model
// Notes: Abort pins get two-clock pulses except the one-clock stop case
`timescale 1ns/100ps
module dma_abort_resume_control_tb;
  import dmaarc_pkg::*;
  logic clk = 1'b0;
  logic arst_n, hsel, hwrite, hready, hreadyout, hresp, stop, nmi;
  logic xfer_req, xfer_ack, irq;
  logic [31:0] haddr, hwdata, hrdata, xfer_src, xfer_dst, r;
  logic [1:0] htrans, xfer_ch;
  logic [2:0] hsize;
  logic [3:0] pirq, pin;
  logic [7:0] lat; // Model answer delay
  int fails = 0;
  int n_tests = 0;
  assign hready = hreadyout; // Single slave drives the bus ready
  always #4 clk = ~clk;
  dmaarc_core dut (.clk(clk), .arst_n(arst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .periph_irq(pirq),
    .transfer_request_pin(pin), .transfer_stop_input(stop), .nmi(nmi),
    .xfer_req(xfer_req), .xfer_ch(xfer_ch), .xfer_src(xfer_src),
    .xfer_dst(xfer_dst), .xfer_ack(xfer_ack), .irq(irq));
  dmaarc_sys_model model (.clk(clk), .arst_n(arst_n), .xfer_req(xfer_req),
    .xfer_ch(xfer_ch), .lat(lat), .xfer_ack(xfer_ack));
  // Compare one value and count it
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One single AHB transfer; waits on ready in both phases
  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    chk("bus resp", 32'h0, {31'h0, hresp});
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(a, 1'b1, d, x);
  endtask : wr
  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
    logic [31:0] x;
    bus(a, 1'b0, 32'h0000_0000, x);
    chk(nm, e, x);
  endtask : rchk
  // Byte address of a field in a channel window
  function automatic logic [7:0] ca(input int c, input logic [4:0] f);
    return {1'b0, 2'(c), f};
  endfunction : ca
  task automatic prog(input int c, input logic [31:0] s, d,
                      input logic [15:0] n, adc, input logic [7:0] ctl);
    wr(ca(c, FLD_SRC), s);
    wr(ca(c, FLD_DST), d);
    wr(ca(c, FLD_CNT), {16'h0000, n});
    wr(ca(c, FLD_ADC), {16'h0000, adc});
    wr(ca(c, FLD_CTL), {24'h00_0000, ctl});
  endtask : prog
  // Bounded wait for a channel's total of finished words
  task automatic wait_acks(input int c, input int n);
    int k;
    k = 0;
    while (model.acks[c] < n && k < 3000) begin @(posedge clk); k++; end
    chk("ack count", 32'(n), 32'(model.acks[c]));
    repeat (2) @(posedge clk);
  endtask : wait_acks
  task automatic wait_req;
    int k;
    k = 0;
    while (xfer_req !== 1'b1 && k < 3000) begin @(posedge clk); k++; end
    chk("req up", 32'h1, {31'h0, xfer_req});
  endtask : wait_req
  // Two-clock pin pulse, then low so the next pulse is a fresh edge
  task automatic pin_pulse(input logic [3:0] m);
    pin <= m;
    repeat (2) @(posedge clk);
    pin <= 4'h0;
    repeat (2) @(posedge clk);
  endtask : pin_pulse
  task give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : give_verdict
  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (50000) @(posedge clk);
    fails++;
    give_verdict();
  end
  initial begin
    {arst_n, hsel, hwrite, stop, nmi} = 5'h00;
    {haddr, hwdata, htrans, pirq, pin, lat} = '0;
    hsize = 3'h2;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rchk("ctl reset", ca(0, FLD_CTL), 32'h0);
    rchk("istat reset", OFS_ISTAT, 32'h0);
    rchk("unmapped", 8'ha0, 32'h0);
    $display("test reset done");
    // Dummy-style transfer: same addresses, count 1, control 0000H
    prog(0, 32'h100, 32'h100, 16'h0001, 16'h0000, 8'h03);
    wait_acks(0, 1);
    rchk("ctl0 armed", ca(0, FLD_CTL), 32'h1);
    // Single mode moves one word per start
    wr(ca(0, FLD_CTL), 32'h3);
    wait_acks(0, 2);
    rchk("src0", ca(0, FLD_SRC), 32'h108);
    rchk("dst0", ca(0, FLD_DST), 32'h108);
    rchk("ctl0 end", ca(0, FLD_CTL), 32'h0);
    rchk("irq st", OFS_IRQ_ST, 32'h1);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(OFS_IRQ_EN, 32'hff);
    rchk("irq en", OFS_IRQ_EN, 32'hff);
    chk("irq on", 32'h1, {31'h0, irq});
    wr(OFS_IRQ_CLR, 32'hff);
    rchk("irq clr", OFS_IRQ_ST, 32'h0);
    chk("irq off", 32'h0, {31'h0, irq});
    $display("test dummy transfer done");
    // Every mode, prompt and slow answers
    for (int m = 0; m < 3; m++) begin
      lat <= 8'(m * 3);
      prog(1, 32'h400, 32'h800, 16'h0002, 16'h0000, 8'(3 + 4 * m));
      // Single mode needs a fresh start for every word
      if (m == 0) begin
        wait_acks(1, 1);
        wr(ca(1, FLD_CTL), 32'h3);
        wait_acks(1, 2);
        wr(ca(1, FLD_CTL), 32'h3);
      end
      wait_acks(1, 3 * (m + 1));
      rchk("src1", ca(1, FLD_SRC), 32'h40c);
    end
    $display("test modes done");
    // Peripheral start, both addresses counting down
    prog(2, 32'h500, 32'h600, 16'h0000, 16'h0005, 8'h11);
    pirq <= 4'h4;
    wait_acks(2, 1);
    pirq <= 4'h0;
    rchk("dst2", ca(2, FLD_DST), 32'h5fc);
    rchk("irq done", OFS_IRQ_ST, 32'h06);
    $display("test peripheral start done");
    // Pin start aborted by the interrupt line, then resumed
    wr(OFS_IRQ_CLR, 32'hff);
    lat <= 8'd20;
    prog(0, 32'h200, 32'h300, 16'h0003, 16'h0008, 8'h21);
    pin_pulse(4'h1);
    wait_acks(0, 3);
    // Single mode: each word needs its own pin edge
    pin_pulse(4'h1);
    wait_req();
    chk("req ch", 32'h0, {30'h0, xfer_ch});
    chk("req src", 32'h204, xfer_src);
    chk("req dst", 32'h300, xfer_dst);
    nmi <= 1'b1;
    repeat (2) @(posedge clk);
    nmi <= 1'b0;
    repeat (6) @(posedge clk);
    chk("req aborted", 32'h0, {31'h0, xfer_req});
    rchk("istat nmi", OFS_ISTAT, 32'h1);
    rchk("irq abort", OFS_IRQ_ST, 32'h10);
    rchk("cnt0 left", ca(0, FLD_CNT), 32'h2);
    rchk("src0 left", ca(0, FLD_SRC), 32'h204);
    wr(OFS_RST, 32'h1);
    wait_acks(0, 4);
    pin_pulse(4'h1);
    wait_acks(0, 5);
    pin_pulse(4'h1);
    wait_acks(0, 6);
    rchk("src0 resumed", ca(0, FLD_SRC), 32'h210);
    rchk("dst0 fixed", ca(0, FLD_DST), 32'h300);
    rchk("irq resumed", OFS_IRQ_ST, 32'h11);
    $display("test nmi abort done");
    // One-clock stop pulse on a pin-started single transfer
    wr(OFS_IRQ_CLR, 32'hff);
    prog(3, 32'h700, 32'h700, 16'h0001, 16'h0000, 8'h21);
    pin_pulse(4'h8);
    wait_req();
    chk("req ch3", 32'h3, {30'h0, xfer_ch});
    chk("req dst3", 32'h700, xfer_dst);
    stop <= 1'b1;
    @(posedge clk);
    stop <= 1'b0;
    repeat (6) @(posedge clk);
    chk("req stopped", 32'h0, {31'h0, xfer_req});
    bus(OFS_ISTAT, 1'b0, 32'h0000_0000, r);
    chk("istat stop", 32'h1, {31'h0, r[3]});
    wr(OFS_RST, 32'h8);
    wait_acks(3, 1);
    pin_pulse(4'h8);
    wait_acks(3, 2);
    rchk("irq stop", OFS_IRQ_ST, 32'h88);
    $display("test stop abort done");
    // Two-clock stop on a stepped run; a long level aborts once
    prog(1, 32'h400, 32'h800, 16'h0001, 16'h0000, 8'h07);
    wait_req();
    stop <= 1'b1;
    repeat (2) @(posedge clk);
    stop <= 1'b0;
    repeat (6) @(posedge clk);
    rchk("istat long stop", OFS_ISTAT, 32'h2);
    rchk("cnt1 kept", ca(1, FLD_CNT), 32'h1);
    wr(OFS_RST, 32'h2);
    wait_acks(1, 11);
    rchk("src1 resumed", ca(1, FLD_SRC), 32'h408);
    $display("test long stop done");
    give_verdict();
  end
endmodule : dma_abort_resume_control_tb
